// [rtl/flash_protect_defines.vh]
// How it works
// - Mask ROM is always read-protected; flash only once protection is on.
// - Protection starts only after a password is stored in loader mode 6.
// - Password bit 7 clear selects type zero: only program flash guarded.
// - Password bit 7 set selects type one: both flash banks guarded.
// - Dual-bank type zero: program flash readable only by code in program flash.
// - Dual-bank: any protection type refuses program or erase of program flash.
// - Type zero: data flash readable by code from any region.
// - Type one: flash readable only by code in either flash bank.
// - Dual-bank type zero: data flash program allowed, erase needs enable bit.
// - Unlock by matching password in loader mode; auto-erase program flash, password.
// - After unlock, protection holds until the next reset.
// - Dual-bank: bit 7 set erases all banks; clear erases program bank.
// - Sector variant: bit 7 set guards whole flash, erases all sectors.
// - Sector variant: code 10 guards every sector; codes 1-9 guard sectors below the code; others none.
// - Sector variant: one protection type for the whole flash.
`ifndef FLASH_PROTECT_DEFINES_VH
`define FLASH_PROTECT_DEFINES_VH

// Register offsets
`define REG_MISC_CTRL 4'h0
`define REG_PW_PROGRAM 4'h4
`define REG_PW_UNLOCK 4'h8
`define REG_STATUS 4'hC

// Field positions
`define MISC_ERASE_EN_BIT 0
`define PW_TYPE_BIT 7
`define PW_SECT_HI 6
`define PW_SECT_LO 3

// Reset values
`define MISC_RESET 8'h00
`define PW_RESET 8'h00

// Boot loader mode that stores or checks the password
`define LOADER_MODE_PW 3'h6

// Code and target regions
`define REGION_PFLASH 2'h0
`define REGION_DFLASH 2'h1
`define REGION_ROM 2'h2
`define REGION_OTHER 2'h3

// Sector field codes
`define SECT_CODE_ALL 4'hA
`define SECT_CODE_MAX 4'h9

`endif

// [rtl/flash_readout_erase_protection.v]
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "flash_protect_defines.vh"

module flash_readout_erase_protection #(
	parameter SECTOR_VARIANT = 0,
	parameter NUM_SECTORS = 16
) (
	// Clock and reset
	input wire core_clk,
	input wire reset_n,
	// Register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	// Boot loader pins
	input wire bootstrap_loader,
	input wire [2:0] bootstrap_loader_mode,
	// Nonvolatile password store
	input wire [7:0] stored_password,
	input wire stored_valid,
	output reg password_write,
	output reg [7:0] password_write_data,
	output reg password_erase,
	// CPU read check
	input wire rd_req,
	input wire [1:0] rd_target,
	input wire [1:0] fetch_region,
	output reg rd_grant,
	output reg rd_deny,
	// Program and erase requests
	input wire pe_req,
	input wire pe_erase,
	input wire pe_bank,
	input wire [3:0] pe_sector,
	output reg pe_go,
	output reg pe_fail,
	// Unlock auto-erase
	output reg auto_erase,
	output reg auto_erase_pflash,
	output reg auto_erase_dflash,
	output reg [NUM_SECTORS-1:0] auto_erase_sectors
);

	// Sectors guarded by the sector field of a password
	function [NUM_SECTORS-1:0] sector_mask;
		input [7:0] pw;
		reg [3:0] code;
		integer i;
		begin
			code = pw[`PW_SECT_HI:`PW_SECT_LO];
			sector_mask = {NUM_SECTORS{1'b0}};
			if (pw[`PW_TYPE_BIT] || code == `SECT_CODE_ALL)
				sector_mask = {NUM_SECTORS{1'b1}};
			else if (code != 4'h0 && code <= `SECT_CODE_MAX)
			begin
				for (i = 0; i < NUM_SECTORS; i = i + 1)
					if (i < code)
						sector_mask[i] = 1'b1;
			end
		end
	endfunction

	// Synchronised boot loader pins
	reg loader_meta;
	reg loader_sync;
	reg [2:0] mode_meta;
	reg [2:0] mode_sync;

	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			loader_meta <= 1'b0;
			loader_sync <= 1'b0;
			mode_meta <= 3'h0;
			mode_sync <= 3'h0;
		end
		else
		begin
			loader_meta <= bootstrap_loader;
			loader_sync <= loader_meta;
			mode_meta <= bootstrap_loader_mode;
			mode_sync <= mode_meta;
		end
	end

	wire loader_pw_mode;
	assign loader_pw_mode = loader_sync &&
		(mode_sync == `LOADER_MODE_PW);

	// Protection state caught after reset release
	reg loaded;
	reg prot_on;
	reg type_one;
	reg [7:0] pw_copy;
	reg [NUM_SECTORS-1:0] guard_sectors;

	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			loaded <= 1'b0;
			prot_on <= 1'b1;
			type_one <= 1'b1;
			pw_copy <= `PW_RESET;
			guard_sectors <= {NUM_SECTORS{1'b1}};
		end
		else if (!loaded)
		begin
			loaded <= 1'b1;
			prot_on <= stored_valid;
			type_one <= stored_password[`PW_TYPE_BIT];
			pw_copy <= stored_password;
			guard_sectors <= sector_mask(stored_password);
		end
	end

	// Register decode
	wire wr_misc;
	wire wr_pw_prog;
	wire wr_unlock;
	assign wr_misc = reg_write && reg_addr == `REG_MISC_CTRL;
	assign wr_pw_prog = reg_write && reg_addr == `REG_PW_PROGRAM;
	assign wr_unlock = reg_write && reg_addr == `REG_PW_UNLOCK;

	// Erase enable, consumed by each data flash erase granted under protection
	reg data_flash_erase_enable;
	reg [6:0] misc_spare;
	wire erase_en_used;

	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{misc_spare, data_flash_erase_enable} <=
				`MISC_RESET;
		end
		else
		begin
			if (wr_misc)
			begin
				data_flash_erase_enable <=
					reg_wdata[`MISC_ERASE_EN_BIT];
				misc_spare <= reg_wdata[7:1];
			end
			else if (erase_en_used)
				data_flash_erase_enable <= 1'b0;
		end
	end

	// Read permission
	reg next_rd_ok;
	wire from_flash;
	assign from_flash = fetch_region == `REGION_PFLASH ||
		fetch_region == `REGION_DFLASH;

	always @*
	begin
		next_rd_ok = 1'b0;
		if (loaded)
		begin
			case (rd_target)
			`REGION_ROM:
				next_rd_ok = fetch_region == `REGION_ROM;
			`REGION_PFLASH:
				if (!prot_on)
					next_rd_ok = 1'b1;
				else if (type_one)
					next_rd_ok = from_flash;
				else if (SECTOR_VARIANT != 0)
					next_rd_ok = 1'b1;
				else
					next_rd_ok =
						fetch_region == `REGION_PFLASH;
			`REGION_DFLASH:
				if (!prot_on || !type_one)
					next_rd_ok = 1'b1;
				else
					next_rd_ok = from_flash;
			default:
				next_rd_ok = 1'b1;
			endcase
		end
	end

	// Program and erase permission
	reg next_pe_ok;
	wire sector_guarded;
	assign sector_guarded = pe_sector < NUM_SECTORS &&
		guard_sectors[pe_sector];

	always @*
	begin
		next_pe_ok = 1'b0;
		if (!loaded)
			next_pe_ok = 1'b0;
		else if (!prot_on)
			next_pe_ok = 1'b1;
		else if (SECTOR_VARIANT != 0)
		begin
			if (type_one)
				next_pe_ok = 1'b0;
			else
				next_pe_ok = !(pe_erase && sector_guarded);
		end
		else if (!pe_bank)
			next_pe_ok = 1'b0;
		else if (type_one)
			next_pe_ok = 1'b0;
		else
			next_pe_ok = !pe_erase ||
				data_flash_erase_enable;
	end

	assign erase_en_used = pe_req && pe_erase && pe_bank &&
		next_pe_ok && prot_on && SECTOR_VARIANT == 0;

	// Request answers
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_grant <= 1'b0;
			rd_deny <= 1'b0;
			pe_go <= 1'b0;
			pe_fail <= 1'b0;
		end
		else
		begin
			rd_grant <= rd_req && next_rd_ok;
			rd_deny <= rd_req && !next_rd_ok;
			pe_go <= pe_req && next_pe_ok;
			pe_fail <= pe_req && !next_pe_ok;
		end
	end

	// Password program and unlock in loader mode
	reg unlocked;
	reg unlock_fail;
	reg pw_written;
	wire unlock_match;
	assign unlock_match = wr_unlock && loader_pw_mode && loaded &&
		prot_on && !unlocked && reg_wdata == pw_copy;

	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			password_write <= 1'b0;
			password_write_data <= `PW_RESET;
			password_erase <= 1'b0;
			pw_written <= 1'b0;
			unlocked <= 1'b0;
			unlock_fail <= 1'b0;
			auto_erase <= 1'b0;
			auto_erase_pflash <= 1'b0;
			auto_erase_dflash <= 1'b0;
			auto_erase_sectors <= {NUM_SECTORS{1'b0}};
		end
		else
		begin
			password_write <= 1'b0;
			password_erase <= 1'b0;
			auto_erase <= 1'b0;
			if (wr_pw_prog && loader_pw_mode && loaded &&
				!prot_on && !pw_written)
			begin
				password_write <= 1'b1;
				password_write_data <= reg_wdata;
				pw_written <= 1'b1;
			end
			if (unlock_match)
			begin
				unlocked <= 1'b1;
				unlock_fail <= 1'b0;
				password_erase <= 1'b1;
				auto_erase <= 1'b1;
				auto_erase_pflash <= 1'b1;
				auto_erase_dflash <= type_one;
				auto_erase_sectors <= (SECTOR_VARIANT != 0) ?
					guard_sectors : {NUM_SECTORS{1'b0}};
			end
			else if (wr_unlock && loader_pw_mode && prot_on &&
				!unlocked)
				unlock_fail <= 1'b1;
		end
	end

	// Register read data, one cycle after the strobe
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (reg_read)
		begin
			case (reg_addr)
			`REG_MISC_CTRL:
				reg_rdata <= {misc_spare, data_flash_erase_enable};
			`REG_STATUS:
				reg_rdata <= {2'h0, pw_written, unlock_fail,
					unlocked, type_one, prot_on, loaded};
			default:
				reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

endmodule // flash_readout_erase_protection

// [dv/password_store.sv]
`timescale 1ns/1ps
module password_store (
	// Clock
	input wire core_clk,
	// Device side
	input wire password_write,
	input wire [7:0] password_write_data,
	input wire password_erase,
	output reg [7:0] stored_password,
	output reg stored_valid
);
	initial stored_password = 8'hFF;
	initial stored_valid = 1'h0;
	// Nonvolatile, so reset leaves it alone
	always @(posedge core_clk)
		if (password_write)
		begin
			stored_password <= password_write_data;
			stored_valid <= 1'h1;
		end
		else if (password_erase)
		begin
			stored_password <= ~stored_password;
			stored_valid <= 1'h0;
		end
endmodule // password_store

// [dv/flash_protect_monitor.sv]
`timescale 1ns/1ps
module flash_protect_monitor (
	// Clock and reset
	input wire core_clk,
	input wire reset_n,
	// Password store
	input wire [7:0] stored_password,
	input wire stored_valid,
	input wire password_erase,
	// Read check
	input wire rd_req,
	input wire [1:0] rd_target,
	input wire [1:0] fetch_region,
	input wire rd_grant,
	input wire rd_deny,
	// Program and erase
	input wire pe_req,
	input wire pe_bank,
	input wire pe_go,
	input wire pe_fail,
	// Unlock
	input wire auto_erase,
	input wire auto_erase_pflash
);
	reg ld;
	reg prot;
	reg one;
	// Mirror of the state taken after reset
	always @(posedge core_clk or negedge reset_n)
		if (!reset_n)
			ld <= 1'h0;
		else if (!ld)
		begin
			ld <= 1'h1;
			prot <= stored_valid;
			one <= stored_password[7];
		end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_rd_one_answer: assert property (
		rd_req |=> rd_grant != rd_deny) else $error("read answer bad");
	a_pe_one_answer: assert property (
		pe_req |=> pe_go != pe_fail) else $error("pe answer bad");
	a_no_stray_pulse: assert property (
		!rd_req && !pe_req |=> !(rd_grant | rd_deny | pe_go | pe_fail))
		else $error("stray answer");
	a_rom_read_guard: assert property (
		rd_req && rd_target == 2'h2 && fetch_region != 2'h2 |=> rd_deny)
		else $error("rom read leaked");
	a_unlock_erase: assert property (
		auto_erase |-> password_erase && auto_erase_pflash)
		else $error("unlock erase incomplete");
	a_erase_held: assert property (
		!$fell(auto_erase_pflash)) else $error("erase flag dropped");
	a_pflash_pe_guard: assert property (
		pe_req && ld && prot && !pe_bank |=> pe_fail)
		else $error("pflash change allowed");
	a_type_one_read: assert property (
		rd_req && ld && prot && one && !rd_target[1] && fetch_region[1]
		|=> rd_deny) else $error("type one read leaked");
	a_open_read: assert property (
		rd_req && ld && !prot && rd_target != 2'h2 |=> rd_grant)
		else $error("unprotected read denied");
endmodule // flash_protect_monitor
bind flash_readout_erase_protection flash_protect_monitor i_mon (
	.core_clk, .reset_n, .stored_password, .stored_valid, .password_erase,
	.rd_req, .rd_target, .fetch_region, .rd_grant, .rd_deny, .pe_req,
	.pe_bank, .pe_go, .pe_fail, .auto_erase, .auto_erase_pflash);

// [dv/flash_readout_erase_protection_bench.sv]
`timescale 1ns/1ps
module flash_readout_erase_protection_bench;
	logic core_clk = 1'h0;
	logic reset_n = 1'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'h0, reg_read = 1'h0, rd_req = 1'h0, pe_req = 1'h0;
	logic pe_erase = 1'h0, pe_bank = 1'h0, bootstrap_loader = 1'h1;
	logic [2:0] bootstrap_loader_mode = 3'h6;
	logic [1:0] rd_target = 2'h0, fetch_region = 2'h0;
	logic [3:0] pe_sector = 4'h0;
	wire [7:0] reg_rdata, stored_password, password_write_data;
	wire stored_valid, password_write, password_erase, rd_grant, rd_deny;
	wire pe_go, pe_fail, auto_erase, auto_erase_pflash, auto_erase_dflash;
	wire [15:0] auto_erase_sectors;
	int bad_count = 0, comparisons = 0, cyc = 0;

	always #2 core_clk = ~core_clk;

	flash_readout_erase_protection i_dut (.core_clk, .reset_n, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .bootstrap_loader,
		.bootstrap_loader_mode, .stored_password, .stored_valid,
		.password_write, .password_write_data, .password_erase, .rd_req,
		.rd_target, .fetch_region, .rd_grant, .rd_deny, .pe_req, .pe_erase,
		.pe_bank, .pe_sector, .pe_go, .pe_fail, .auto_erase,
		.auto_erase_pflash, .auto_erase_dflash, .auto_erase_sectors);
	password_store i_store (.core_clk, .password_write,
		.password_write_data, .password_erase, .stored_password,
		.stored_valid);

	task complete_run;
		$display("mismatches %0d of %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task cmp(input logic [7:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t got %h want %h", $time, got, exp);
		end
	endtask
	task rst;
		// Let the last pulse reach the password store first
		@(posedge core_clk);
		reset_n <= 1'h0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'h1;
		repeat (4) @(posedge core_clk);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_write <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_write <= 1'h0;
		#1;
	endtask
	task rr(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_read <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_read <= 1'h0;
		#1 cmp(reg_rdata, e);
	endtask
	task rd(input logic [1:0] t, f, input logic g);
		@(posedge core_clk);
		rd_req <= 1'h1;
		rd_target <= t;
		fetch_region <= f;
		@(posedge core_clk);
		rd_req <= 1'h0;
		#1 cmp({rd_grant, rd_deny}, {g, ~g});
	endtask
	task pe(input logic e, b, g);
		@(posedge core_clk);
		pe_req <= 1'h1;
		pe_erase <= e;
		pe_bank <= b;
		@(posedge core_clk);
		pe_req <= 1'h0;
		#1 cmp({pe_go, pe_fail}, {g, ~g});
	endtask

	// Hang guard
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			bad_count++;
			complete_run;
		end
	end

	initial
	begin
		rst;
		rd(2'h0, 2'h3, 1'h1);
		pe(1'h1, 1'h0, 1'h1);
		wr(4'h4, 8'h80);
		cmp({7'h00, password_write}, 8'h01);
		cmp(password_write_data, 8'h80);
		rst;
		rr(4'hC, 8'h07);
		rr(4'h2, 8'h00);
		rd(2'h0, 2'h2, 1'h0);
		rd(2'h1, 2'h1, 1'h1);
		rd(2'h2, 2'h0, 1'h0);
		pe(1'h0, 1'h1, 1'h0);
		pe(1'h1, 1'h0, 1'h0);
		wr(4'h8, 8'h80);
		cmp({auto_erase, password_erase, auto_erase_pflash,
			auto_erase_dflash}, 8'h0F);
		cmp(auto_erase_sectors[7:0], 8'h00);
		cmp(auto_erase_sectors[15:8], 8'h00);
		rd(2'h0, 2'h2, 1'h0);
		rr(4'hC, 8'h0F);
		rst;
		rd(2'h0, 2'h2, 1'h1);
		wr(4'h4, 8'h05);
		rst;
		rd(2'h0, 2'h1, 1'h0);
		rd(2'h0, 2'h0, 1'h1);
		rd(2'h1, 2'h2, 1'h1);
		pe(1'h1, 1'h1, 1'h0);
		wr(4'h0, 8'h01);
		pe(1'h1, 1'h1, 1'h1);
		pe(1'h1, 1'h1, 1'h0);
		rr(4'h0, 8'h00);
		pe(1'h0, 1'h1, 1'h1);
		pe(1'h1, 1'h0, 1'h0);
		wr(4'h8, 8'h06);
		rr(4'hC, 8'h13);
		complete_run;
	end
endmodule // flash_readout_erase_protection_bench
